// ### core/sfc_pkg.sv
// Purpose: shared constants and types of the serial flash command front end
// Assumes: opcodes are one byte, sent most significant bit first
// Notes: counts are in link clock bits, not reference clock cycles
package sfc_pkg;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] read_cmd = 8'h03;
	localparam logic [7:0] fast_read_cmd = 8'h0B;
	localparam logic [7:0] dual_line_read_cmd = 8'hBB;
	localparam logic [7:0] quad_line_read_cmd = 8'hEB;
	localparam logic [7:0] set_write_latch_cmd = 8'h06;
	localparam logic [7:0] clear_write_latch_cmd = 8'h04;
	localparam logic [7:0] status_read_cmd = 8'h05;
	localparam logic [7:0] status_write_cmd = 8'h01;
	localparam logic [7:0] sector_erase_cmd = 8'h20;
	localparam logic [7:0] half_block_erase_cmd = 8'h52;
	localparam logic [7:0] block_erase_cmd = 8'hD8;
	localparam logic [7:0] chip_erase_cmd = 8'h60;
	localparam logic [7:0] chip_erase_alt_cmd = 8'hC7;
	localparam logic [7:0] page_program_cmd = 8'h02;
	localparam logic [7:0] quad_page_program_cmd = 8'h38;
	localparam logic [7:0] deep_sleep_cmd = 8'hB9;
	localparam logic [7:0] deep_sleep_exit_cmd = 8'hAB;

	// ----------------------------------------------------------------
	// bit and byte counts
	// ----------------------------------------------------------------
	localparam logic [4:0] opcode_bits = 5'h08;
	localparam logic [4:0] addr_bits = 5'h18;
	localparam logic [4:0] dummy_bits = 5'h08;
	localparam logic [4:0] byte_bits = 5'h08;
	localparam logic [2:0] bytes_opcode_only = 3'h1;
	localparam logic [2:0] bytes_status_write = 3'h2;
	localparam logic [2:0] bytes_addressed = 3'h4;
	localparam logic [2:0] bytes_program_min = 3'h5;
	localparam logic [2:0] lanes_single = 3'h1;
	localparam logic [2:0] lanes_dual = 3'h2;
	localparam logic [2:0] lanes_quad = 3'h4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] status_bits_rst = 6'h00;
	localparam logic [3:0] ref_sync_rst = 4'hC;

	typedef enum logic [2:0] {
		ph_opcode = 3'b000,
		ph_addr = 3'b001,
		ph_dummy = 3'b010,
		ph_dout = 3'b011,
		ph_din = 3'b100,
		ph_standby = 3'b101
	} sfc_phase_t;

	typedef enum logic [3:0] {
		kind_none = 4'b0000,
		kind_erase_sector = 4'b0001,
		kind_erase_half = 4'b0010,
		kind_erase_block = 4'b0011,
		kind_erase_chip = 4'b0100,
		kind_program = 4'b0101,
		kind_program_quad = 4'b0110,
		kind_status_write = 4'b0111,
		kind_deep_sleep = 4'b1000,
		kind_deep_wake = 4'b1001,
		kind_latch_set = 4'b1010,
		kind_latch_clear = 4'b1011
	} sfc_kind_t;

	typedef struct packed {
		sfc_kind_t kind;
		logic [23:0] addr;
		logic [7:0] value;
	} sfc_cmd_t;

endpackage

// ### core/sfc_front_end.sv
// Purpose: serial interface front end of a serial NOR flash, opcode decode
// Assumes: host keeps the serial clock still while chip select is high
// Notes: link logic runs on the serial clock, command launch on REF_CLK_I
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - unknown opcode gives standby, output off, until next chip select fall
// - known opcode makes the device active until chip select rises, except reads while busy and all but AB while asleep
// - inputs sampled on rising clock, outputs shifted on falling clock
// - clock may idle low or high; both supported modes behave alike
// - read types stream data after header; host may stop after any bit
// - write-type commands run only if chip select rises on a byte boundary
// - while busy, array reads are ignored and erases or programs are not launched, but program data still pulses PROG_VALID_O
// - hold pauses only the serial link, never a running operation
// - hold starts at once on hold falling, whatever the clock level
// - hold ends on hold rising with clock low, else when clock falls
// - during hold output is off, data input and clock are ignored
// - chip select high during hold resets the link logic
// - opcodes 03, 0B, BB, EB pick read variant; three address bytes follow
// - fast, dual and quad reads add one dummy byte; plain read none
// - 06 sets write latch, 04 clears it, 05 returns status
// - 01 with one value byte loads the status register
// - 20 erases a 4KB sector, 52 a 32KB block, with address
// - D8 with address erases a 64KB block
// - 02 programs a page on one line, 38 on four lines
// - 60 or C7 erase the chip; B9 sleeps, AB wakes
// - content-changing commands need the write latch set first
// - write latch clears on reset, write disable and operation completion
module sfc_front_end (
	// reference clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	// serial link
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic HOLD_N_I,
	input wire logic [3:0] IO_I,
	output logic [3:0] IO_O,
	output logic [3:0] IO_OE_O,
	// array read port, link clock
	output logic [23:0] MEM_ADDR_O,
	input wire logic [7:0] MEM_DATA_I,
	// program data stream, reference clock
	output logic PROG_VALID_O,
	output logic [7:0] PROG_DATA_O,
	// command launch, reference clock
	output logic CMD_VALID_O,
	output sfc_pkg::sfc_cmd_t CMD_O,
	input wire logic BUSY_I,
	input wire logic DONE_I,
	// device state
	output logic [7:0] STATUS_O,
	output logic ACTIVE_O,
	output logic HOLD_O,
	output logic SLEEP_O
);
	import sfc_pkg::*;

	function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] n,
		input logic [3:0] d);
		shift_in = (n == lanes_quad) ? {v[19:0], d} :
			(n == lanes_dual) ? {v[21:0], d[1:0]} : {v[22:0], d[0]};
	endfunction

	// ----------------------------------------------------------------
	// link domain state
	// ----------------------------------------------------------------
	wire link_rst = RST_I | CS_N_I;
	wire oe_rst = link_rst | ~HOLD_N_I;

	logic fresh_reg, fresh_next;
	sfc_phase_t phase_reg, phase_next, phase_cur;
	logic [2:0] lanes_reg, lanes_next, lanes_cur;
	logic [4:0] cnt_reg, cnt_next, cnt_cur, cnt_step;
	logic [2:0] bitpos_reg, bitpos_next, bitpos_cur;
	logic [2:0] bytes_reg, bytes_next, bytes_cur;
	logic [7:0] sh_reg, sh_next;
	logic [7:0] opcode_reg, opcode_next;
	logic [23:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic ptog_reg, ptog_next;
	logic active_reg, active_next;
	logic [8:0] lsync1_reg, lsync2_reg;
	logic [2:0] ocnt_reg;
	logic [7:0] out_sh_reg;
	logic [3:0] io_o_reg, io_oe_reg;

	// a new frame is seen through the fresh flag, so nothing needs a clock edge
	// before the first one; registers the reference side reads survive the frame, except active_reg
	assign phase_cur = fresh_reg ? ph_opcode : phase_reg;
	assign lanes_cur = fresh_reg ? lanes_single : lanes_reg;
	assign cnt_cur = fresh_reg ? 5'h00 : cnt_reg;
	assign bitpos_cur = fresh_reg ? 3'h0 : bitpos_reg;
	assign bytes_cur = fresh_reg ? 3'h0 : bytes_reg;
	assign cnt_step = cnt_cur + {2'b00, lanes_cur};

	wire [3:0] bit_sum = {1'b0, bitpos_cur} + {1'b0, lanes_cur};
	wire byte_done = bit_sum[3];
	wire [23:0] sh_wide = shift_in({16'h0000, sh_reg}, lanes_cur, IO_I);
	wire [7:0] op_in = sh_wide[7:0];
	wire busy_l = lsync2_reg[0];
	wire sleep_l = lsync2_reg[8];

	// ----------------------------------------------------------------
	// opcode decode
	// ----------------------------------------------------------------
	wire dec_dual = op_in == dual_line_read_cmd;
	wire dec_quad = op_in == quad_line_read_cmd;
	wire dec_read = (op_in == read_cmd) | (op_in == fast_read_cmd) | dec_dual | dec_quad;
	wire dec_erase = (op_in == sector_erase_cmd) | (op_in == half_block_erase_cmd) |
		(op_in == block_erase_cmd);
	wire dec_prog = (op_in == page_program_cmd) | (op_in == quad_page_program_cmd);
	wire dec_addressed = dec_read | dec_erase | dec_prog;
	wire dec_plain = (op_in == set_write_latch_cmd) | (op_in == clear_write_latch_cmd) |
		(op_in == chip_erase_cmd) | (op_in == chip_erase_alt_cmd) |
		(op_in == deep_sleep_cmd) | (op_in == deep_sleep_exit_cmd) |
		(op_in == status_write_cmd);
	wire dec_status = op_in == status_read_cmd;
	// while asleep only the wake opcode is heard; array reads are dropped while busy
	wire dec_valid = (dec_addressed | dec_plain | dec_status) &&
		(!sleep_l || op_in == deep_sleep_exit_cmd) && !(busy_l && dec_read);
	wire sfc_phase_t dec_phase = !dec_valid ? ph_standby :
		dec_status ? ph_dout : dec_addressed ? ph_addr : ph_din;
	wire [2:0] dec_lanes = dec_dual ? lanes_dual :
		(dec_quad | op_in == quad_page_program_cmd) ? lanes_quad : lanes_single;

	wire op_is_read = (opcode_reg == read_cmd) | (opcode_reg == fast_read_cmd) |
		(opcode_reg == dual_line_read_cmd) | (opcode_reg == quad_line_read_cmd);
	wire op_is_prog = (opcode_reg == page_program_cmd) |
		(opcode_reg == quad_page_program_cmd);

	always_comb begin
		fresh_next = fresh_reg;
		phase_next = phase_reg;
		lanes_next = lanes_reg;
		cnt_next = cnt_reg;
		bitpos_next = bitpos_reg;
		bytes_next = bytes_reg;
		sh_next = sh_reg;
		opcode_next = opcode_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		ptog_next = ptog_reg;
		active_next = active_reg;
		// held: clock and data input are ignored, everything keeps its value
		if (HOLD_N_I) begin
			fresh_next = 1'b0;
			phase_next = phase_cur;
			lanes_next = lanes_cur;
			cnt_next = cnt_step;
			bitpos_next = bit_sum[2:0];
			bytes_next = (byte_done && bytes_cur != 3'h7) ? bytes_cur + 3'h1 : bytes_cur;
			sh_next = op_in;
			unique case (phase_cur)
				ph_opcode: begin
					if (cnt_step == opcode_bits) begin
						opcode_next = op_in;
						cnt_next = 5'h00;
						active_next = dec_valid;
						lanes_next = dec_lanes;
						phase_next = dec_phase;
					end
				end
				ph_addr: begin
					addr_next = shift_in(addr_reg, lanes_cur, IO_I);
					if (cnt_step == addr_bits) begin
						cnt_next = 5'h00;
						if (!op_is_read) begin
							phase_next = ph_din;
						end else if (opcode_reg == read_cmd) begin
							phase_next = ph_dout;
						end else begin
							phase_next = ph_dummy;
						end
					end
				end
				ph_dummy: begin
					if (cnt_step == dummy_bits) begin
						cnt_next = 5'h00;
						phase_next = ph_dout;
					end
				end
				ph_dout: begin
					if (cnt_step == byte_bits) begin
						cnt_next = 5'h00;
						addr_next = addr_reg + 24'h00_0001;
					end
				end
				ph_din: begin
					if (byte_done) begin
						data_next = op_in;
						ptog_next = ptog_reg ^ op_is_prog;
					end
				end
				ph_standby: begin
					cnt_next = 5'h00;
				end
				default: begin
					phase_next = ph_standby;
				end
			endcase
		end
	end

	// both clock idle levels work: only edges are used, never the idle level
	always_ff @(posedge SCLK_I or posedge link_rst) begin
		if (link_rst) begin
			fresh_reg <= 1'b1;
			active_reg <= 1'b0;
		end else begin
			fresh_reg <= fresh_next;
			active_reg <= active_next;
		end
	end

	always_ff @(posedge SCLK_I or posedge RST_I) begin
		if (RST_I) begin
			phase_reg <= ph_standby;
			lanes_reg <= lanes_single;
			cnt_reg <= 5'h00;
			bitpos_reg <= 3'h0;
			bytes_reg <= 3'h0;
			sh_reg <= 8'h00;
			opcode_reg <= 8'h00;
			addr_reg <= 24'h00_0000;
			data_reg <= 8'h00;
			ptog_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			lanes_reg <= lanes_next;
			cnt_reg <= cnt_next;
			bitpos_reg <= bitpos_next;
			bytes_reg <= bytes_next;
			sh_reg <= sh_next;
			opcode_reg <= opcode_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			ptog_reg <= ptog_next;
		end
	end

	// ----------------------------------------------------------------
	// status sync on the rising edge, output shifter on the falling edge
	// ----------------------------------------------------------------
	logic [8:0] status_pack;
	logic [7:0] status_reg;
	logic sleep_reg;
	assign status_pack = {sleep_reg, status_reg};

	always_ff @(posedge SCLK_I or posedge RST_I) begin
		if (RST_I) begin
			lsync1_reg <= 9'h000;
			lsync2_reg <= 9'h000;
		end else begin
			lsync1_reg <= status_pack;
			lsync2_reg <= lsync1_reg;
		end
	end

	wire drive = !fresh_reg && phase_reg == ph_dout;
	wire [7:0] byte_src = (opcode_reg == status_read_cmd) ? lsync2_reg[7:0] : MEM_DATA_I;
	wire [7:0] out_cur = (ocnt_reg == 3'h0) ? byte_src : out_sh_reg;
	wire [3:0] io_val = (lanes_reg == lanes_quad) ? out_cur[7:4] :
		(lanes_reg == lanes_dual) ? {2'b00, out_cur[7:6]} : {2'b00, out_cur[7], 1'b0};
	wire [7:0] out_shifted = (lanes_reg == lanes_quad) ? {out_cur[3:0], 4'h0} :
		(lanes_reg == lanes_dual) ? {out_cur[5:0], 2'b00} : {out_cur[6:0], 1'b0};
	wire [3:0] oe_mask = (lanes_reg == lanes_quad) ? 4'hF :
		(lanes_reg == lanes_dual) ? 4'h3 : 4'h2;

	always_ff @(negedge SCLK_I or posedge link_rst) begin
		if (link_rst) begin
			ocnt_reg <= 3'h0;
			out_sh_reg <= 8'h00;
			io_o_reg <= 4'h0;
		end else if (drive && HOLD_N_I) begin
			ocnt_reg <= ocnt_reg + lanes_reg;
			out_sh_reg <= out_shifted;
			io_o_reg <= io_val;
		end
	end

	// the enable clears at once on chip select high or hold, with no clock edge
	always_ff @(negedge SCLK_I or posedge oe_rst) begin
		if (oe_rst) begin
			io_oe_reg <= 4'h0;
		end else begin
			io_oe_reg <= drive ? oe_mask : 4'h0;
		end
	end

	assign IO_O = io_o_reg;
	assign IO_OE_O = io_oe_reg;
	assign MEM_ADDR_O = addr_reg;

	// ----------------------------------------------------------------
	// reference domain: crossings and command launch
	// ----------------------------------------------------------------
	logic [3:0] rsync1_reg, rsync2_reg;
	logic [1:0] rsync3_reg;
	wire [3:0] rsync_in = {CS_N_I, HOLD_N_I, active_reg, ptog_reg};

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rsync1_reg <= ref_sync_rst;
			rsync2_reg <= ref_sync_rst;
			rsync3_reg <= 2'b10;
		end else begin
			rsync1_reg <= rsync_in;
			rsync2_reg <= rsync1_reg;
			rsync3_reg <= {rsync2_reg[3], rsync2_reg[0]};
		end
	end

	wire cs_rise = rsync2_reg[3] & ~rsync3_reg[1];
	wire prog_ev = rsync2_reg[0] ^ rsync3_reg[0];

	// link registers are still once chip select is high, so they are read as they stand
	sfc_kind_t kind;
	logic [2:0] need_bytes;
	always_comb begin
		kind = kind_none;
		need_bytes = bytes_opcode_only;
		unique case (opcode_reg)
			set_write_latch_cmd: kind = kind_latch_set;
			clear_write_latch_cmd: kind = kind_latch_clear;
			status_write_cmd: begin
				kind = kind_status_write;
				need_bytes = bytes_status_write;
			end
			sector_erase_cmd: begin
				kind = kind_erase_sector;
				need_bytes = bytes_addressed;
			end
			half_block_erase_cmd: begin
				kind = kind_erase_half;
				need_bytes = bytes_addressed;
			end
			block_erase_cmd: begin
				kind = kind_erase_block;
				need_bytes = bytes_addressed;
			end
			chip_erase_cmd, chip_erase_alt_cmd: kind = kind_erase_chip;
			page_program_cmd: begin
				kind = kind_program;
				need_bytes = bytes_program_min;
			end
			quad_page_program_cmd: begin
				kind = kind_program_quad;
				need_bytes = bytes_program_min;
			end
			deep_sleep_cmd: kind = kind_deep_sleep;
			deep_sleep_exit_cmd: kind = kind_deep_wake;
			default: kind = kind_none;
		endcase
	end

	logic wel_reg, wel_next;
	logic sleep_next;
	logic [5:0] sr_bits_reg, sr_bits_next;
	logic cmd_valid_reg;
	sfc_cmd_t cmd_reg, cmd_next;
	logic prog_valid_reg;
	logic [7:0] prog_data_reg;
	logic active_o_reg, hold_o_reg;

	wire is_prog_kind = kind == kind_program || kind == kind_program_quad;
	wire len_ok = is_prog_kind ? bytes_reg >= need_bytes : bytes_reg == need_bytes;
	wire exec = cs_rise && bitpos_reg == 3'h0 && phase_reg != ph_standby &&
		kind != kind_none && len_ok;
	wire needs_latch = kind != kind_latch_set && kind != kind_latch_clear &&
		kind != kind_deep_sleep && kind != kind_deep_wake;
	wire launch = exec && needs_latch && wel_reg && !BUSY_I;

	// a latch set in the same cycle as a completion wins over the clear
	assign wel_next = (exec && kind == kind_latch_set) ? 1'b1 :
		((exec && kind == kind_latch_clear) || DONE_I) ? 1'b0 : wel_reg;
	assign sleep_next = (exec && kind == kind_deep_sleep) ? 1'b1 :
		(exec && kind == kind_deep_wake) ? 1'b0 : sleep_reg;
	assign sr_bits_next = (launch && kind == kind_status_write) ? data_reg[7:2] :
		sr_bits_reg;
	assign cmd_next = launch ? {kind, addr_reg, data_reg} : cmd_reg;

	// hold is not seen here, so a running operation carries on through it
	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			wel_reg <= 1'b0;
			sleep_reg <= 1'b0;
			sr_bits_reg <= status_bits_rst;
			status_reg <= 8'h00;
			cmd_valid_reg <= 1'b0;
			cmd_reg <= '0;
		end else begin
			wel_reg <= wel_next;
			sleep_reg <= sleep_next;
			sr_bits_reg <= sr_bits_next;
			status_reg <= {sr_bits_reg, wel_reg, BUSY_I};
			cmd_valid_reg <= launch;
			cmd_reg <= cmd_next;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			prog_valid_reg <= 1'b0;
			prog_data_reg <= 8'h00;
			active_o_reg <= 1'b0;
			hold_o_reg <= 1'b0;
		end else begin
			prog_valid_reg <= prog_ev;
			prog_data_reg <= prog_ev ? data_reg : prog_data_reg;
			active_o_reg <= rsync2_reg[1];
			hold_o_reg <= ~rsync2_reg[2] & ~rsync2_reg[3];
		end
	end

	assign CMD_VALID_O = cmd_valid_reg;
	assign CMD_O = cmd_reg;
	assign PROG_VALID_O = prog_valid_reg;
	assign PROG_DATA_O = prog_data_reg;
	assign STATUS_O = status_reg;
	assign SLEEP_O = sleep_reg;
	assign ACTIVE_O = active_o_reg;
	assign HOLD_O = hold_o_reg;

endmodule
`default_nettype wire

// ### sim/sfc_front_end_properties.sv
// Purpose: concurrent checks on the ports of the serial flash front end
// Assumes: all checks run in the reference clock domain
// Notes: link-side pins are sampled by the reference clock, so slow frames only
`timescale 1ns/10ps
`default_nettype none
module sfc_front_end_chk (
	// reference clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_I,
	// link pins
	input wire logic CS_N_I,
	input wire logic HOLD_N_I,
	input wire logic [3:0] IO_OE_O,
	// engine side
	input wire logic BUSY_I,
	input wire logic DONE_I,
	input wire logic CMD_VALID_O,
	input wire logic PROG_VALID_O,
	// device state
	input wire logic [7:0] STATUS_O,
	input wire logic ACTIVE_O,
	input wire logic HOLD_O
);
	default clocking @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	chk_oe_deselect: assert property (CS_N_I |-> IO_OE_O == 4'h0)
		else $error("output enabled while deselected");
	chk_oe_hold: assert property (!HOLD_N_I && !CS_N_I |-> IO_OE_O == 4'h0)
		else $error("output enabled during hold");
	chk_oe_lanes: assert property (IO_OE_O inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("illegal output lane set");
	chk_launch_pulse: assert property (CMD_VALID_O |=> !CMD_VALID_O)
		else $error("launch longer than one cycle");
	chk_launch_after_cs: assert property (
		CMD_VALID_O |-> CS_N_I && $past(CS_N_I) && $past(CS_N_I, 2))
		else $error("launch without a finished frame");
	chk_launch_latch: assert property (CMD_VALID_O |-> STATUS_O[1])
		else $error("launch without write latch");
	chk_launch_idle: assert property (CMD_VALID_O |-> !STATUS_O[0])
		else $error("launch while engine busy");
	chk_status_busy: assert property (STATUS_O[0] == $past(BUSY_I))
		else $error("status busy bit does not follow engine");
	chk_latch_done: assert property (DONE_I && CS_N_I |-> ##[2:3] !STATUS_O[1])
		else $error("write latch kept after completion");
	chk_prog_pulse: assert property (PROG_VALID_O |=> !PROG_VALID_O)
		else $error("program strobe longer than one cycle");

	cov_launch: cover property (CMD_VALID_O);
	cov_prog: cover property (PROG_VALID_O);
	cov_hold: cover property (HOLD_O);
	cov_active: cover property ($rose(ACTIVE_O));
endmodule

bind sfc_front_end sfc_front_end_chk u_chk (
	.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I), .HOLD_N_I(HOLD_N_I),
	.IO_OE_O(IO_OE_O), .BUSY_I(BUSY_I), .DONE_I(DONE_I), .CMD_VALID_O(CMD_VALID_O),
	.PROG_VALID_O(PROG_VALID_O), .STATUS_O(STATUS_O), .ACTIVE_O(ACTIVE_O),
	.HOLD_O(HOLD_O)
);
`default_nettype wire

// ### sim/sfc_host_model.sv
// Purpose: host controller model driving the serial link of the front end
// Assumes: one lane, or four for quad reads; clock period 64 ns, under every read limit
// Notes: released lines toggle each clock so stale values never look valid
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model (
	// device side of the data lines
	input wire logic [3:0] dut_io_i,
	input wire logic [3:0] dut_oe_i,
	// link control
	output logic sclk_o,
	output logic cs_n_o,
	output logic hold_n_o,
	// resolved data lines
	output logic [3:0] wire_o
);
	logic [3:0] drv, drv_en;
	logic flip, cpol;
	logic [63:0] rx_q;

	assign wire_o = (dut_oe_i & dut_io_i) | (~dut_oe_i & drv_en & drv) |
		(~dut_oe_i & ~drv_en & {4{flip}});

	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		hold_n_o = 1'b1;
		drv = 4'h0;
		drv_en = 4'h0;
		flip = 1'b0;
		cpol = 1'b0;
	end

	// clock idles at the chosen polarity outside frames
	task cs_low(input logic pol);
		cpol = pol;
		sclk_o = pol;
		#5;
		cs_n_o = 1'b0;
		#16;
	endtask

	task bits(input logic [63:0] tx, input int n, input int nrx);
		rx_q = '0;
		for (int i = 0; i < n + nrx; i++) begin
			sclk_o = 1'b0;
			drv_en[0] = (i < n);
			drv[0] = (i < n) ? tx[n - 1 - i] : drv[0];
			#32;
			sclk_o = 1'b1;
			flip = ~flip;
			if (i >= n) rx_q = {rx_q[62:0], wire_o[1]};
			#32;
		end
	endtask

	// four lanes each way: address, dummy and data of quad reads
	task quad(input logic [63:0] tx, input int n, input int nrx);
		rx_q = '0;
		for (int i = 0; i < n + nrx; i++) begin
			sclk_o = 1'b0;
			drv_en = (i < n) ? 4'hF : 4'h0;
			drv = (i < n) ? tx[4 * (n - 1 - i) +: 4] : drv;
			#32;
			sclk_o = 1'b1;
			flip = ~flip;
			if (i >= n) rx_q = {rx_q[59:0], wire_o};
			#32;
		end
	endtask

	// callers end frames on byte boundaries unless a refusal is wanted
	task cs_high;
		sclk_o = cpol;
		drv_en = 4'h0;
		#16;
		cs_n_o = 1'b1;
		#16;
	endtask

	// hold moves only with the clock low
	task pause(input logic v);
		sclk_o = 1'b0;
		#16;
		hold_n_o = v;
		#16;
	endtask
endmodule
`default_nettype wire

// ### sim/test_serial_flash_command_front_end.sv
// Purpose: self-checking bench of the serial flash command front end
// Assumes: host model drives the link, bench plays array and erase engine
// Notes: array byte is address low byte xor 5A, so neighbours differ
`timescale 1ns/10ps
`default_nettype none
module test_serial_flash_command_front_end;
	import sfc_pkg::*;
	logic clk, rst, busy, done, pv, cv, act, hld, slp, sclk, csn, holdn;
	logic [3:0] io_o, io_oe, io_w;
	logic [23:0] maddr;
	logic [7:0] pd, st;
	sfc_cmd_t cmd;
	wire [7:0] mem_data = maddr[7:0] ^ 8'h5A;
	int miscompares, checks_done, ncmd;
	logic [7:0] pq[$];
	logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
	sfc_kind_t kinds [5] = '{kind_erase_sector, kind_erase_half, kind_erase_block,
		kind_erase_chip, kind_erase_chip};

	sfc_host_model host (.dut_io_i(io_o), .dut_oe_i(io_oe), .sclk_o(sclk), .cs_n_o(csn),
		.hold_n_o(holdn), .wire_o(io_w));
	sfc_front_end dut (.REF_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk), .CS_N_I(csn),
		.HOLD_N_I(holdn), .IO_I(io_w), .IO_O(io_o), .IO_OE_O(io_oe), .MEM_ADDR_O(maddr),
		.MEM_DATA_I(mem_data), .PROG_VALID_O(pv), .PROG_DATA_O(pd),
		.CMD_VALID_O(cv), .CMD_O(cmd), .BUSY_I(busy), .DONE_I(done), .STATUS_O(st),
		.ACTIVE_O(act), .HOLD_O(hld), .SLEEP_O(slp));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (pv === 1'b1) pq.push_back(pd);
		if (cv === 1'b1) ncmd++;
	end

	// engine stand-in: busy a few cycles per launch, then a done pulse
	initial forever begin
		@(posedge clk iff cv === 1'b1);
		#1 busy = 1'b1;
		repeat (5) @(posedge clk);
		#1 busy = 1'b0;
		done = 1'b1;
		@(posedge clk);
		#1 done = 1'b0;
	end

	task cmp(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task tally_and_finish;
		if (miscompares == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// frame end must be seen through the synchroniser before the next one
	task cs_end;
		host.cs_high();
		repeat (8) @(posedge clk);
		#1;
	endtask

	task frame(input logic [63:0] tx, input int n, input int nrx, input logic pol);
		host.cs_low(pol);
		host.bits(tx, n, nrx);
		cs_end();
	endtask

	task settle;
		int k;
		for (k = 0; k < 30 && (busy | done); k++) @(posedge clk);
		if (k == 30) begin
			miscompares++;
			tally_and_finish();
		end
		repeat (3) @(posedge clk);
		#1;
	endtask

	task t_basic;
		cmp(st, 8'h00);
		cmp(io_oe, 4'h0);
		frame(8'h06, 8, 0, 1'b0);
		cmp(st[1], 1'b1);
		frame(8'h04, 8, 0, 1'b1);
		cmp(st[1], 1'b0);
		frame(9'h00C, 9, 0, 1'b0);
		cmp(st[1], 1'b0);
	endtask

	task t_status;
		frame(8'h06, 8, 0, 1'b0);
		host.cs_low(1'b0);
		host.bits(8'h05, 8, 16);
		cmp(act, 1'b1);
		cmp(host.rx_q[15:0], 16'h0202);
		cs_end();
		cmp(act, 1'b0);
		frame(8'h04, 8, 0, 1'b0);
		host.cs_low(1'b0);
		host.bits(8'h9F, 8, 16);
		cmp(io_oe, 4'h0);
		cmp(act, 1'b0);
		cs_end();
	endtask

	task t_read;
		frame({8'h03, 24'h000010}, 32, 16, 1'b0);
		cmp(host.rx_q[15:0], 16'h4A4B);
		frame({8'h0B, 24'h000020, 8'h00}, 40, 8, 1'b1);
		cmp(host.rx_q[7:0], 8'h7A);
	endtask

	task t_quad;
		host.cs_low(1'b0);
		host.bits(8'hEB, 8, 0);
		host.quad({24'h00_0030, 8'h00}, 8, 4);
		cmp(io_oe, 4'hF);
		cmp(host.rx_q[15:0], 16'h6A6B);
		cs_end();
		cmp(io_oe, 4'h0);
	endtask

	task t_erase;
		int c0;
		for (int i = 0; i < 5; i++) begin
			c0 = ncmd;
			cmp(st[0], 1'b0);
			frame(8'h06, 8, 0, 1'b0);
			if (i < 3) frame({ops[i], 24'h012340 + 24'(i)}, 32, 0, 1'b0);
			else frame(ops[i], 8, 0, 1'b0);
			settle();
			cmp(ncmd, c0 + 1);
			cmp(cmd.kind, kinds[i]);
			if (i < 3) cmp(cmd.addr, 24'h012340 + 24'(i));
			cmp(st[1], 1'b0);
		end
		c0 = ncmd;
		frame({8'h20, 24'h000000}, 32, 0, 1'b0);
		frame(8'h06, 8, 0, 1'b0);
		frame({8'h20, 24'h000000, 1'b1}, 33, 0, 1'b0);
		cmp(ncmd, c0);
		frame(8'h04, 8, 0, 1'b0);
	endtask

	task t_write;
		frame(8'h06, 8, 0, 1'b0);
		frame({8'h01, 8'hFC}, 16, 0, 1'b0);
		settle();
		cmp(cmd.kind, kind_status_write);
		cmp(cmd.value, 8'hFC);
		cmp(st, 8'hFC);
		pq.delete();
		frame(8'h06, 8, 0, 1'b0);
		frame({8'h02, 24'h000100, 16'hA55A}, 48, 0, 1'b0);
		settle();
		cmp(cmd.kind, kind_program);
		cmp(pq.size(), 2);
		cmp({pq[0], pq[1]}, 16'hA55A);
	endtask

	task t_sleep;
		frame(8'hB9, 8, 0, 1'b0);
		cmp(slp, 1'b1);
		host.cs_low(1'b0);
		host.bits(8'h05, 8, 8);
		cmp(io_oe, 4'h0);
		cs_end();
		frame(8'hAB, 8, 0, 1'b0);
		cmp(slp, 1'b0);
	endtask

	task t_hold;
		host.cs_low(1'b0);
		host.bits(4'h0, 4, 0);
		host.pause(1'b0);
		repeat (6) @(posedge clk);
		#1;
		cmp(hld, 1'b1);
		host.bits(4'hF, 4, 0);
		host.pause(1'b1);
		host.bits(4'h6, 4, 0);
		cs_end();
		cmp(st[1], 1'b1);
		host.cs_low(1'b0);
		host.bits(4'h0, 4, 0);
		host.pause(1'b0);
		cs_end();
		host.pause(1'b1);
		frame(8'h04, 8, 0, 1'b0);
		cmp(st[1], 1'b0);
	endtask

	initial begin
		rst = 1'b1;
		busy = 1'b0;
		done = 1'b0;
		miscompares = 0;
		checks_done = 0;
		ncmd = 0;
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		t_basic();
		t_status();
		t_read();
		t_quad();
		t_erase();
		t_hold();
		t_sleep();
		t_write();
		tally_and_finish();
	end
endmodule
`default_nettype wire
